// >>> ccu_params.svh
`ifndef CCU_PARAMS_SVH
`define CCU_PARAMS_SVH
// ----------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------
`define CCU_IDX_PORT_B 8'h06
`define CCU_IDX_PIN_DATA 8'h07
`define CCU_IDX_INT_CTRL 8'h0b
`define CCU_IDX_FLAGS 8'h0c
`define CCU_IDX_TMR_LOW 8'h0e
`define CCU_IDX_TMR_HIGH 8'h0f
`define CCU_IDX_TMR_CTRL 8'h10
`define CCU_IDX_CAP_LOW 8'h15
`define CCU_IDX_CAP_HIGH 8'h16
`define CCU_IDX_MOD_CTRL 8'h17
`define CCU_IDX_PORT_B_DIR 8'h86
`define CCU_IDX_PIN_DIR 8'h87
`define CCU_IDX_ENABLES 8'h8c
// ----------------------------------------
// Field positions, masks and reset values
// ----------------------------------------
`define CCU_BIT_MOD_FLAG 2
`define CCU_BIT_TMR_FLAG 0
`define CCU_BIT_PIN 2
`define CCU_BIT_PORT 3
`define CCU_MASK_FLAGS 8'h47
`define CCU_MASK_PIN 8'h05
`define CCU_MASK_CTRL 6'h3f
`define CCU_MASK_TCTL 6'h3f
`define CCU_RST_PIN_DIR 8'h05
`define CCU_RST_ZERO8 8'h00
// ----------------------------------------
// Mode select encodings
// ----------------------------------------
`define CCU_MODE_OFF 4'h0
`define CCU_MODE_CMP_SET 4'h8
`define CCU_MODE_CMP_CLR 4'h9
`define CCU_MODE_CMP_IRQ 4'ha
`define CCU_MODE_CMP_SPEC 4'hb
`define CCU_GRP_CAP 2'h1
`define CCU_GRP_CMP 2'h2
`define CCU_GRP_PWM 2'h3
`define CCU_SEL_FALL 2'h0
`define CCU_SEL_RISE 2'h1
`define CCU_SEL_RISE4 2'h2
`define CCU_SEL_RISE16 2'h3
`define CCU_PRE4_LAST 2'h3
`define CCU_PRE16_LAST 4'hf
`endif

// >>> ccu_pkg.sv
package ccu_pkg;
  // ----------------------------------------
  // Operating group decoded from the mode bits
  // ----------------------------------------
  typedef enum logic [1:0] {ccu_off, ccu_capture, ccu_compare, ccu_pwm} ccu_group_e;
  // ----------------------------------------
  // Whole state of the core module
  // ----------------------------------------
  typedef struct packed {
    logic [5:0] ctrl;       // Duty low bits and mode select bits
    logic [15:0] value;     // Capture or compare value
    logic [7:0] flags;      // Peripheral flags
    logic [7:0] enables;    // Peripheral enables
    logic [7:0] int_ctrl;   // Interrupt control storage
    logic [5:0] tmr_ctrl;   // Timer control, drives the timer outside
    logic [7:0] pin_dir;    // Pin direction bits
    logic [7:0] pin_data;   // Pin data bits latch
    logic port_data;        // Port bit 3 data latch
    logic port_dir;         // Port bit 3 direction, 1 is input
    logic cmp_latch;        // Compare output latch
    logic ack;              // Bus answer cycle
    logic [7:0] rdata;      // Read data byte
  } ccu_state_s;
  // ----------------------------------------
  // Prescaler state
  // ----------------------------------------
  typedef struct packed {
    logic prev;             // Level seen last cycle
    logic [3:0] count;      // Rising edge count
  } ccu_pre_s;
endpackage

// >>> ccu_cap_if.sv
`timescale 1ns/1ps
// Capture edge path between the core and the prescaler
interface ccu_cap_if;
  logic ce;                 // Clock enable
  logic level;              // Pin level to watch
  logic cap_en;             // Capture mode active
  logic [1:0] edge_sel;     // Event selection
  logic event_hit;          // One-cycle capture event
  modport core (output ce, output level, output cap_en, output edge_sel, input event_hit);
  modport pre (input ce, input level, input cap_en, input edge_sel, output event_hit);
endinterface

// >>> ccu_prescaler.sv
`timescale 1ns/1ps
`include "ccu_params.svh"
module ccu_prescaler (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Capture path
  ccu_cap_if.pre cap
);
  ccu_pkg::ccu_pre_s st;      // Registered state
  ccu_pkg::ccu_pre_s next_st; // Next state
  logic rise;                 // Rising edge this cycle
  logic fall;                 // Falling edge this cycle

  // ----------------------------------------
  // Edge detection and prescaler counting
  // ----------------------------------------
  always_comb begin
    next_st = st;
    rise = cap.level & ~st.prev;
    fall = ~cap.level & st.prev;
    next_st.prev = cap.level;
    if (!cap.cap_en) begin
      next_st.count = 4'h0;
    end else if (rise) begin
      next_st.count = st.count + 4'h1;
    end
  end

  always_comb begin
    case (cap.edge_sel)
      `CCU_SEL_FALL: cap.event_hit = cap.cap_en & cap.ce & fall;
      `CCU_SEL_RISE: cap.event_hit = cap.cap_en & cap.ce & rise;
      `CCU_SEL_RISE4: cap.event_hit = cap.cap_en & cap.ce & rise & (st.count[1:0] == `CCU_PRE4_LAST);
      default: cap.event_hit = cap.cap_en & cap.ce & rise & (st.count == `CCU_PRE16_LAST);
    endcase
  end

  // State register, frozen while the clock enable is low
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      st <= '0;
    end else if (cap.ce) begin
      st <= next_st;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  a_prescale_cleared: assert property (cap.ce && !cap.cap_en |=> st.count == 4'h0)
    else $error("prescaler count not cleared outside capture");
  a_fourth_edge: assert property (cap.edge_sel == `CCU_SEL_RISE4 && cap.event_hit |-> st.count[1:0] == 2'h3)
    else $error("fourth edge event at wrong count");
  c_sixteenth: cover property (cap.edge_sel == `CCU_SEL_RISE16 && cap.event_hit);
endmodule

// >>> ccu_core.sv
// Design decision made here: register access over Avalon-MM.
`timescale 1ns/1ps
`include "ccu_params.svh"
// Operation
// - capture copies 16-bit timer on event
// - events falling, rising, 4th, 16th rising
// - mode encodings off, capture, compare, PWM
// - capture sets sticky flag bit 2
// - new capture overwrites old value
// - output direction lets data bit trigger capture
// - mode change may raise spurious flag
// - prescaler cleared when off or non-capture
// - prescaler switch keeps count, clear first
// - compare match drives pin, sets flag
// - control write zero clears compare latch
// - interrupt-only match sets flag, pin unchanged
// - special event resets timer to zero
// - special event starts conversion, no overflow flag
// - module off leaves port bit normal
// - port bit reads, data bit reads pin unless off
// - port writes never drive owned pin
// - compare and PWM modes drive pin
module ccu_core (
  // Clock, reset and enable
  input wire logic clock,
  input wire logic rst_b,
  input wire logic ce,
  // Avalon-MM slave
  input wire logic [9:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Timer outside the block
  input wire logic [15:0] timer_value,
  input wire logic timer_overflow,
  output logic [5:0] timer_ctrl,
  output logic timer_clear,
  // Converter and PWM generator
  input wire logic adc_enabled,
  output logic adc_start,
  input wire logic pwm_level,
  // Shared module pin
  input wire logic pin_in,
  output logic pin_out,
  output logic pin_oe
);
  ccu_pkg::ccu_state_s st;      // Registered state
  ccu_pkg::ccu_state_s next_st; // Next state
  ccu_pkg::ccu_group_e grp;     // Decoded operating group
  ccu_cap_if cap ();            // Capture path to the prescaler
  logic [7:0] index;            // Register index from the byte address
  logic req;                    // Bus request present
  logic do_write;               // Write takes effect this edge
  logic [7:0] wbyte;            // Written byte
  logic [3:0] mode;             // Mode select bits
  logic match;                  // Compare equality this cycle
  logic cmp_hit;                // Match that counts this cycle
  logic pin_in_dir;             // Module pin set as input
  logic [7:0] rd_mux;           // Read data selection

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  // group from mode select bits
  always_comb begin
    mode = st.ctrl[3:0];
    if (mode == `CCU_MODE_OFF) begin
      grp = ccu_pkg::ccu_off;
    end else if (mode[3:2] == `CCU_GRP_CAP) begin
      grp = ccu_pkg::ccu_capture;
    end else if (mode[3:2] == `CCU_GRP_CMP) begin
      grp = ccu_pkg::ccu_compare;
    end else if (mode[3:2] == `CCU_GRP_PWM) begin
      grp = ccu_pkg::ccu_pwm;
    end else begin
      // Codes 0001 to 0011 are unused and behave as off
      grp = ccu_pkg::ccu_off;
    end
  end

  // Bus strobes; a write lands only at the edge where waitrequest is low
  assign index = address[9:2];
  assign req = read | write;
  assign waitrequest = req & ~(st.ack & ce);
  assign do_write = write & st.ack & ce & byteenable[0];
  assign wbyte = writedata[7:0];
  assign readdata = {24'h000000, st.rdata};
  assign pin_in_dir = st.pin_dir[`CCU_BIT_PIN];

  // ----------------------------------------
  // Compare path
  // ----------------------------------------
  // continuous equality against the timer
  assign match = (st.value == timer_value);
  assign cmp_hit = ce & match & (grp == ccu_pkg::ccu_compare);
  assign timer_clear = cmp_hit & (mode == `CCU_MODE_CMP_SPEC);
  // conversion start only with converter enabled
  assign adc_start = timer_clear & adc_enabled;
  assign timer_ctrl = st.tmr_ctrl;

  // ----------------------------------------
  // Capture path
  // ----------------------------------------
  // pin level includes our own drive, so a data write can capture
  assign cap.level = pin_in;
  assign cap.ce = ce;
  assign cap.cap_en = (grp == ccu_pkg::ccu_capture);
  assign cap.edge_sel = mode[1:0];

  ccu_prescaler u_pre (
    .clock(clock),
    .rst_b(rst_b),
    .cap(cap.pre)
  );

  // ----------------------------------------
  // Pin drive
  // ----------------------------------------
  // Pin mux from registered state, PWM from the pwm_level input; the owning function decides
  always_comb begin
    case (grp)
      ccu_pkg::ccu_off: begin
        pin_oe = ~st.port_dir;
        pin_out = st.port_data;
      end
      ccu_pkg::ccu_capture: begin
        // data bit, not the port latch, drives the pin
        pin_oe = ~pin_in_dir;
        pin_out = st.pin_data[`CCU_BIT_PIN];
      end
      ccu_pkg::ccu_compare: begin
        pin_oe = ~pin_in_dir;
        pin_out = st.cmp_latch;
      end
      default: begin
        pin_oe = ~pin_in_dir;
        pin_out = pwm_level;
      end
    endcase
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  // address decode, unimplemented bits read zero
  always_comb begin
    rd_mux = 8'h00;
    if (index == `CCU_IDX_PORT_B) begin
      // port bit view depends on the owner
      if (grp == ccu_pkg::ccu_off) begin
        rd_mux[`CCU_BIT_PORT] = st.port_dir ? pin_in : st.port_data;
      end else if (grp == ccu_pkg::ccu_capture && pin_in_dir) begin
        rd_mux[`CCU_BIT_PORT] = 1'b0;
      end else begin
        rd_mux[`CCU_BIT_PORT] = st.port_data;
      end
    end else if (index == `CCU_IDX_PIN_DATA) begin
      rd_mux = st.pin_data;
      // outside off mode the data bit shows the real pin level
      if (grp != ccu_pkg::ccu_off) begin
        rd_mux[`CCU_BIT_PIN] = pin_in;
      end
    end else if (index == `CCU_IDX_INT_CTRL) begin
      rd_mux = st.int_ctrl;
    end else if (index == `CCU_IDX_FLAGS) begin
      rd_mux = st.flags;
    end else if (index == `CCU_IDX_TMR_LOW) begin
      rd_mux = timer_value[7:0];
    end else if (index == `CCU_IDX_TMR_HIGH) begin
      rd_mux = timer_value[15:8];
    end else if (index == `CCU_IDX_TMR_CTRL) begin
      rd_mux = {2'b00, st.tmr_ctrl};
    end else if (index == `CCU_IDX_CAP_LOW) begin
      rd_mux = st.value[7:0];
    end else if (index == `CCU_IDX_CAP_HIGH) begin
      rd_mux = st.value[15:8];
    end else if (index == `CCU_IDX_MOD_CTRL) begin
      rd_mux = {2'b00, st.ctrl};
    end else if (index == `CCU_IDX_PORT_B_DIR) begin
      rd_mux[`CCU_BIT_PORT] = st.port_dir;
    end else if (index == `CCU_IDX_PIN_DIR) begin
      rd_mux = st.pin_dir;
    end else if (index == `CCU_IDX_ENABLES) begin
      rd_mux = st.enables;
    end else begin
      // Unmapped index reads zero
      rd_mux = 8'h00;
    end
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    next_st = st;
    // Answer one cycle after the request is seen
    next_st.ack = req & ~st.ack;
    if (req & ~st.ack) begin
      next_st.rdata = rd_mux;
    end
    // Software writes; unmapped writes are dropped
    if (do_write) begin
      if (index == `CCU_IDX_PORT_B) begin
        // port write only touches its own latch
        next_st.port_data = wbyte[`CCU_BIT_PORT];
      end else if (index == `CCU_IDX_PIN_DATA) begin
        next_st.pin_data = wbyte & `CCU_MASK_PIN;
      end else if (index == `CCU_IDX_INT_CTRL) begin
        next_st.int_ctrl = wbyte;
      end else if (index == `CCU_IDX_FLAGS) begin
        next_st.flags = wbyte & `CCU_MASK_FLAGS;
      end else if (index == `CCU_IDX_TMR_CTRL) begin
        next_st.tmr_ctrl = wbyte[5:0] & `CCU_MASK_TCTL;
      end else if (index == `CCU_IDX_CAP_LOW) begin
        next_st.value[7:0] = wbyte;
      end else if (index == `CCU_IDX_CAP_HIGH) begin
        next_st.value[15:8] = wbyte;
      end else if (index == `CCU_IDX_MOD_CTRL) begin
        next_st.ctrl = wbyte[5:0] & `CCU_MASK_CTRL;
      end else if (index == `CCU_IDX_PORT_B_DIR) begin
        next_st.port_dir = wbyte[`CCU_BIT_PORT];
      end else if (index == `CCU_IDX_PIN_DIR) begin
        next_st.pin_dir = wbyte & `CCU_MASK_PIN;
      end else if (index == `CCU_IDX_ENABLES) begin
        next_st.enables = wbyte & `CCU_MASK_FLAGS;
      end
    end
    // off mode holds the compare latch low
    if (next_st.ctrl[3:0] == `CCU_MODE_OFF) begin
      next_st.cmp_latch = 1'b0;
    end else if (cmp_hit && mode == `CCU_MODE_CMP_SET) begin
      next_st.cmp_latch = 1'b1;
    end else if (cmp_hit && mode == `CCU_MODE_CMP_CLR) begin
      next_st.cmp_latch = 1'b0;
    end
    // capture overwrites the value register, no buffer
    if (cap.event_hit) begin
      next_st.value = timer_value;
    end
    // capture or match sets flag; set beats a clear
    if (cap.event_hit || cmp_hit) begin
      next_st.flags[`CCU_BIT_MOD_FLAG] = 1'b1;
    end
    // only true overflow or a software write sets the timer flag
    if (ce && timer_overflow) begin
      next_st.flags[`CCU_BIT_TMR_FLAG] = 1'b1;
    end
  end

  // State register, frozen while the clock enable is low
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      st <= '0;
      st.pin_dir <= `CCU_RST_PIN_DIR;
      st.port_dir <= 1'b1;
    end else if (ce) begin
      st <= next_st;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  logic cap_wr;  // Helper: software write to the value bytes
  assign cap_wr = do_write && (index == `CCU_IDX_CAP_LOW || index == `CCU_IDX_CAP_HIGH);

  a_capture_copies: assert property (cap.event_hit && !cap_wr |=> st.value == $past(timer_value))
    else $error("capture did not copy timer value");
  a_capture_flag: assert property (cap.event_hit |=> st.flags[`CCU_BIT_MOD_FLAG])
    else $error("capture did not set flag");
  a_flag_sticky: assert property (ce && st.flags[2] && !(do_write && index == `CCU_IDX_FLAGS) |=> st.flags[2])
    else $error("flag dropped without software clear");
  a_match_flag: assert property (cmp_hit |=> st.flags[`CCU_BIT_MOD_FLAG])
    else $error("compare match did not set flag");
  a_set_on_match: assert property (cmp_hit && mode == `CCU_MODE_CMP_SET && !do_write ##1 !pin_in_dir
    |-> pin_oe && pin_out)
    else $error("set on match did not drive pin high");
  a_zero_ctrl: assert property (do_write && index == `CCU_IDX_MOD_CTRL && wbyte == 8'h00 |=> !st.cmp_latch)
    else $error("control zero write kept compare latch");
  a_irq_only: assert property (ce && mode == `CCU_MODE_CMP_IRQ && !do_write |=> $stable(st.cmp_latch))
    else $error("interrupt-only mode changed the pin");
  a_special_reset: assert property (cmp_hit && mode == `CCU_MODE_CMP_SPEC |-> timer_clear
    && (adc_start == adc_enabled))
    else $error("special event did not clear timer");
  a_no_tmr_flag: assert property (ce && !st.flags[0] && !timer_overflow && !do_write |=> !st.flags[0])
    else $error("timer flag set without overflow");
  a_off_pin: assert property (grp == ccu_pkg::ccu_off |-> pin_oe == !st.port_dir && pin_out == st.port_data)
    else $error("off mode pin not plain port");
  a_bus_answer: assert property (ce && req && waitrequest |=> !waitrequest || !ce)
    else $error("bus answer later than one cycle");

  c_capture: cover property (cap.event_hit);
  c_special: cover property (timer_clear && adc_start);
  c_clear_on_match: cover property (cmp_hit && mode == `CCU_MODE_CMP_CLR);
  c_pwm_drive: cover property (grp == ccu_pkg::ccu_pwm && pin_oe);
endmodule

// >>> ccu_pin_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// External circuit on the shared module pin
// ----------------------------------------
module ccu_pin_model (
  // Clock
  input wire logic clock,
  // Design side of the pin
  input wire logic pin_out,
  input wire logic pin_oe,
  // Bench control of the outside driver
  input wire logic ext_drive,
  input wire logic ext_level,
  // Resolved wire level
  output logic pin_in
);
  logic last; // Level seen last cycle
  // Remember the wire so a floating pin never repeats it
  always_ff @(posedge clock) begin
    last <= pin_in;
  end
  assign pin_in = pin_oe ? pin_out : (ext_drive ? ext_level : ~last);
endmodule

// >>> tb_ccu_core.sv
`timescale 1ns/1ps
`include "ccu_params.svh"
module tb_ccu_core;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic clock, rst_b, ce, read, write, tmr_ovf, adc_enabled, pwm_level;
  logic ext_drive, ext_level, pin_in, pin_out, pin_oe, timer_clear, adc_start, waitrequest;
  logic [9:0] address;
  logic [31:0] writedata, readdata;
  logic [15:0] timer_value;
  logic [5:0] timer_ctrl;
  logic [7:0] q;
  int fail_count, check_count;
  localparam logic [9:0] a_port = 10'h018, a_pdat = 10'h01c, a_flags = 10'h030, a_cl = 10'h054;
  localparam logic [9:0] a_ch = 10'h058, a_ctl = 10'h05c, a_pdir = 10'h21c, a_en = 10'h230;
  // ----------------------------------------
  // Design and far side
  // ----------------------------------------
  ccu_core DUT (.clock(clock), .rst_b(rst_b), .ce(ce), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(4'hf), .readdata(readdata),
    .waitrequest(waitrequest), .timer_value(timer_value), .timer_overflow(tmr_ovf),
    .timer_ctrl(timer_ctrl), .timer_clear(timer_clear), .adc_enabled(adc_enabled),
    .adc_start(adc_start), .pwm_level(pwm_level), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe));
  ccu_pin_model far_end (.clock(clock), .pin_out(pin_out), .pin_oe(pin_oe), .ext_drive(ext_drive),
    .ext_level(ext_level), .pin_in(pin_in));
  // Clock of 40 ns
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk_reg(input string nm, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_bit(input string nm, input logic e, input logic g);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected %s expected %b seen %b", nm, e, g);
    end
  endtask
  // One Avalon access; the request stands until the rising edge that samples waitrequest low
  task automatic bus(input logic w, input logic [9:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clock);
    address <= a;
    write <= w;
    read <= ~w;
    writedata <= {24'h000000, d};
    do begin
      @(posedge clock);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    // Pre-edge values: read data taken at the answer edge itself
    q = readdata[7:0];
    if (n >= 50) chk_bit("waitrequest", 1'b0, waitrequest);
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [9:0] a, input logic [7:0] e, input string nm);
    bus(1'b0, a, 8'h00);
    chk_reg(nm, e, q);
  endtask
  // Whole high pulse on the pin, with time for the capture to land
  task automatic pulse(input int n);
    repeat (n) begin
      @(posedge clock);
      ext_level <= 1'b1;
      repeat (3) @(posedge clock);
      ext_level <= 1'b0;
      repeat (4) @(posedge clock);
    end
  endtask
  // Match the compare value for one cycle, then move the timer away
  task automatic hit(input logic [3:0] m, input logic e);
    wr(a_flags, 8'h00);
    wr(a_ctl, {4'h0, m});
    @(posedge clock);
    timer_value <= 16'h2345;
    @(negedge clock);
    chk_bit("timer_clear", m == `CCU_MODE_CMP_SPEC, timer_clear);
    chk_bit("adc_start", m == `CCU_MODE_CMP_SPEC, adc_start);
    @(posedge clock);
    timer_value <= 16'h0000;
    rd(a_flags, 8'h04, "flags");
    chk_bit("pin", e, pin_in);
  endtask
  // Watchdog well beyond the expected run length
  initial begin
    #2000000;
    fail_count++;
    end_sim();
  end
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    logic [15:0] tv;
    int n;
    rst_b = 1'b0; read = 1'b0; write = 1'b0; address = '0; writedata = '0; tmr_ovf = 1'b0;
    adc_enabled = 1'b1; pwm_level = 1'b0; ext_drive = 1'b1; ext_level = 1'b0;
    ce = 1'b1;
    timer_value = 16'h0000; fail_count = 0; check_count = 0;
    repeat (12) @(posedge clock);
    rst_b <= 1'b1;
    rd(a_ctl, 8'h00, "module_control");
    rd(a_flags, 8'h00, "flags");
    rd(a_en, 8'h00, "enables");
    rd(a_pdir, 8'h05, "pin_dir");
    wr(10'h3fc, 8'hff);
    rd(10'h3fc, 8'h00, "unmapped");
    wr(a_ctl, 8'hff);
    rd(a_ctl, 8'h3f, "module_control");
    $display("test reset done");
    // Every capture event kind, including overwrite of an already read value
    for (int m = 4; m < 8; m++) begin
      n = (m == 6) ? 4 : ((m == 7) ? 16 : 1);
      wr(a_ctl, 8'h00);
      wr(a_flags, 8'h00);
      wr(a_ctl, 8'(m));
      pulse(n - 1);
      rd(a_flags, 8'h00, "flags");
      tv = {4'(m), 12'h3c5};
      timer_value <= tv;
      pulse(1);
      rd(a_flags, 8'h04, "flags");
      rd(a_cl, tv[7:0], "capture_low");
      rd(a_ch, tv[15:8], "capture_high");
      timer_value <= ~tv;
      pulse(n);
      rd(a_cl, ~tv[7:0], "capture_low");
      rd(a_ch, ~tv[15:8], "capture_high");
    end
    ext_level <= 1'b1;
    rd(a_port, 8'h00, "port");
    rd(a_pdat, 8'h04, "pin_data");
    wr(a_ctl, 8'h00);
    rd(a_port, 8'h08, "port");
    ext_level <= 1'b0;
    // Leaving capture clears the partial prescaler count
    wr(a_ctl, 8'h06);
    pulse(2);
    wr(a_ctl, 8'h00);
    wr(a_flags, 8'h00);
    wr(a_ctl, 8'h06);
    pulse(3);
    rd(a_flags, 8'h00, "flags");
    pulse(1);
    rd(a_flags, 8'h04, "flags");
    $display("test capture done");
    // Compare modes with the module owning the pin
    wr(a_ctl, 8'h00);
    wr(a_pdir, 8'h00);
    ext_drive <= 1'b0;
    wr(a_cl, 8'h45);
    wr(a_ch, 8'h23);
    hit(4'h8, 1'b1);
    hit(4'ha, 1'b1);
    hit(4'h9, 1'b0);
    hit(4'h8, 1'b1);
    hit(4'hb, 1'b1);
    adc_enabled <= 1'b0;
    timer_value <= 16'h2345;
    @(negedge clock);
    chk_bit("adc_start", 1'b0, adc_start);
    chk_bit("timer_clear", 1'b1, timer_clear);
    @(posedge clock);
    timer_value <= 16'h0000;
    wr(a_ctl, 8'h00);
    wr(a_ctl, 8'h0a);
    @(negedge clock);
    chk_bit("pin", 1'b0, pin_in);
    wr(a_port, 8'h08);
    @(negedge clock);
    chk_bit("pin", 1'b0, pin_in);
    rd(a_pdat, 8'h00, "pin_data");
    $display("test compare done");
    // Waveform from outside passes to the pin
    wr(a_ctl, 8'h0c);
    for (int i = 0; i < 2; i++) begin
      @(posedge clock);
      pwm_level <= ~i[0];
      @(negedge clock);
      chk_bit("pin", ~i[0], pin_in);
    end
    $display("test pwm done");
    // Frozen clock enable ignores a match; overflow sets the timer flag and timer control reaches its output
    wr(a_ctl, 8'h0a);
    wr(a_flags, 8'h00);
    ce <= 1'b0;
    timer_value <= 16'h2345;
    repeat (2) @(posedge clock);
    ce <= 1'b1;
    timer_value <= 16'h0000;
    rd(a_flags, 8'h00, "flags");
    tmr_ovf <= 1'b1;
    @(posedge clock);
    tmr_ovf <= 1'b0;
    rd(a_flags, 8'h01, "flags");
    wr(10'h040, 8'hff);
    rd(10'h040, 8'h3f, "timer_control");
    chk_reg("timer_ctrl", 8'h3f, {2'b00, timer_ctrl});
    // Data bit drives the owned pin and so makes a capture
    wr(a_ctl, 8'h00);
    wr(a_flags, 8'h00);
    wr(a_ctl, 8'h05);
    wr(a_pdat, 8'h04);
    rd(a_flags, 8'h04, "flags");
    $display("test enable done");
    end_sim();
  end
endmodule
